// ===== hdl/adc_serial_output_formatter.sv
// per-channel serial output formatter with test pattern generator
module adc_serial_output_formatter
  import fmt_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_link_clk,
  input wire logic i_rstn,
  input wire logic [SAMPLE_W-1:0] i_sample,
  input wire logic i_sample_valid,
  input wire fmt_cfg_s i_cfg,
  input wire logic i_reg_wr,
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  output logic [7:0] o_reg_rdata,
  output logic o_word_pending,
  output logic o_serial_data,
  output logic o_bit_rate_output_clock,
  output logic o_word_frame_output_clock
);

  function automatic logic [4:0] len_of(input wlen_e w);
    case (w)
      LEN_8: return BITS_8;
      LEN_10: return BITS_10;
      LEN_14: return BITS_14;
      default: return BITS_12;
    endcase
  endfunction : len_of

  // top n bits set, the rest clear
  function automatic logic [15:0] top_mask(input logic [4:0] n);
    return ~(16'hffff >> n);
  endfunction : top_mask

  function automatic logic [15:0] rev16(input logic [15:0] v);
    logic [15:0] r;
    r = 16'h0000;
    for (int i = 0; i < 16; i++)
      r[i] = v[15 - i];
    return r;
  endfunction : rev16

  // {hit, slot}; shared by write and read paths
  function automatic logic [2:0] reg_slot(input logic [7:0] a);
    case (a)
      ADDR_USER_W1_A: return 3'h4;
      ADDR_USER_W1_B: return 3'h5;
      ADDR_USER_W2_A: return 3'h6;
      ADDR_USER_W2_B: return 3'h7;
      default: return 3'h0;
    endcase
  endfunction : reg_slot

  // register file
  logic [7:0] user_reg [4];
  logic [7:0] user_next [4];
  logic [7:0] rdata_next;
  logic [2:0] wr_slot;
  logic [2:0] rd_slot;

  always_comb
  begin
    user_next = user_reg;
    wr_slot = reg_slot(i_reg_addr);
    rd_slot = wr_slot;
    if (i_reg_wr && wr_slot[2])
      user_next[wr_slot[1:0]] = i_reg_wdata;
    rdata_next = rd_slot[2] ? user_reg[rd_slot[1:0]] : 8'h00;
  end

  always_ff @(posedge i_core_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      for (int i = 0; i < 4; i++)
        user_reg[i] <= USER_RESET;
      o_reg_rdata <= 8'h00;
    end
    else
    begin
      user_reg <= user_next;
      o_reg_rdata <= rdata_next;
    end
  end

  // word builder
  fmt_cfg_s cfg_reg, cfg_next;
  lane_word_s word_reg, word_next;
  logic [3:0] last_pat_reg, last_pat_next;
  logic alt_reg, alt_next, req_reg, req_next, pending_next;
  logic ack_s1, ack_s2, link_ack;
  logic busy, build, same_pat, alt_cur, subj, pn_sel;
  logic [4:0] n, len;
  logic [15:0] raw, m;
  logic [11:0] pn_short, pn_long;

  always_comb
  begin
    busy = req_reg != ack_s2;
    build = i_sample_valid && !busy;
    pn_sel = i_cfg.pattern == PAT_PN_LONG || i_cfg.pattern == PAT_PN_SHORT;
    same_pat = i_cfg.pattern == last_pat_reg;
    alt_cur = same_pat && alt_reg;
    n = len_of(i_cfg.wlen);
    len = n;
    subj = 1'b0;
    case (i_cfg.pattern)
      PAT_MID:
      begin
        raw = MIDSCALE;
        subj = 1'b1;
      end
      PAT_PFS:
      begin
        raw = 16'hffff;
        subj = 1'b1;
      end
      PAT_NFS:
      begin
        raw = 16'h0000;
        subj = 1'b1;
      end
      PAT_CHECK: raw = alt_cur ? CHECK_B : CHECK_A;
      PAT_PN_LONG:
      begin
        raw = {pn_long, 4'h0};
        subj = 1'b1;
        len = PN_WORD_BITS;
      end
      PAT_PN_SHORT:
      begin
        raw = {pn_short, 4'h0};
        subj = 1'b1;
        len = PN_WORD_BITS;
      end
      PAT_WORD_TGL: raw = alt_cur ? 16'h0000 : 16'hffff;
      PAT_USER: raw = alt_cur ? {user_reg[2], user_reg[3]} : {user_reg[0], user_reg[1]};
      PAT_BIT_TGL: raw = CHECK_A;
      PAT_SYNC: raw = top_mask(n) >> n[4:1];
      PAT_ONE_HIGH: raw = MIDSCALE;
      PAT_MIXED:
        case (i_cfg.wlen)
          LEN_8: raw = MIX_8;
          LEN_10: raw = MIX_10;
          LEN_14: raw = MIX_14;
          default: raw = MIX_12;
        endcase
      default:
      begin
        // unused codes fall back to live samples
        raw = {i_sample, 4'h0};
        subj = 1'b1;
      end
    endcase
    if (subj && i_cfg.twos)
      raw[15] = ~raw[15];
    m = top_mask(len);
    raw = raw & m;
    if (i_cfg.invert)
      raw = raw ^ m;
    if (i_cfg.lsb_first)
      raw = rev16(raw) << (5'h10 - len);
    word_next = word_reg;
    cfg_next = cfg_reg;
    alt_next = alt_reg;
    last_pat_next = last_pat_reg;
    req_next = req_reg;
    if (build)
    begin
      word_next = {raw, len};
      cfg_next = i_cfg;
      alt_next = !alt_cur;
      last_pat_next = i_cfg.pattern;
      req_next = !req_reg;
    end
    pending_next = req_next != ack_s2;
  end

  always_ff @(posedge i_core_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      word_reg <= IDLE_WORD;
      cfg_reg <= '0;
      alt_reg <= 1'b0;
      last_pat_reg <= PAT_OFF;
      req_reg <= 1'b0;
      ack_s1 <= 1'b0;
      ack_s2 <= 1'b0;
      o_word_pending <= 1'b0;
    end
    else
    begin
      word_reg <= word_next;
      cfg_reg <= cfg_next;
      alt_reg <= alt_next;
      last_pat_reg <= last_pat_next;
      req_reg <= req_next;
      ack_s1 <= link_ack;
      ack_s2 <= ack_s1;
      o_word_pending <= pending_next;
    end
  end

  // generators wait on their seed whenever neither is selected; a direct
  // switch between the two keeps running instead of reseeding
  pn_source u_pn (
    .i_core_clk(i_core_clk),
    .i_rstn(i_rstn),
    .i_restart(!pn_sel),
    .i_advance(build && pn_sel),
    .o_short_word(pn_short),
    .o_long_word(pn_long)
  );

  // word and phase cross on a toggle handshake; the word is held until acked
  lane_serializer u_lane (
    .i_link_clk(i_link_clk),
    .i_rstn(i_rstn),
    .i_word(word_reg),
    .i_req_tgl(req_reg),
    .i_phase(cfg_reg.dco_phase),
    .o_ack_tgl(link_ack),
    .o_data(o_serial_data),
    .o_dco(o_bit_rate_output_clock),
    .o_fco(o_word_frame_output_clock)
  );

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rstn);

  sequence s_check_repeat;
    build && i_cfg.pattern == PAT_CHECK && same_pat && i_cfg.wlen == LEN_12;
  endsequence

  sequence s_plain_build;
    build && !i_cfg.invert && !i_cfg.lsb_first;
  endsequence

  a_len_eight: assert property (
    (build && i_cfg.wlen == LEN_8 && !pn_sel)
    |=> word_reg.len == BITS_8 && word_reg.bits[7:0] == 8'h00)
    else $error("8-bit word not shortened");

  a_len_fourteen: assert property (
    (s_plain_build and (i_cfg.wlen == LEN_14 && i_cfg.pattern == PAT_OFF
     && !i_cfg.twos))
    |=> word_reg.len == BITS_14 && word_reg.bits[3:0] == 4'h0
        && word_reg.bits[15:4] == $past(i_sample))
    else $error("14-bit word lacks trailing zeros");

  a_invert_all: assert property (
    (build && i_cfg.pattern == PAT_PFS && i_cfg.invert && !i_cfg.twos)
    |=> word_reg.bits == 16'h0000)
    else $error("inverted full scale not all zero");

  a_lsb_order: assert property (
    (build && i_cfg.pattern == PAT_ONE_HIGH && i_cfg.lsb_first
     && !i_cfg.invert && i_cfg.wlen == LEN_12)
    |=> word_reg.bits == 16'h0010)
    else $error("lsb-first word misordered");

  a_alt_words: assert property (
    s_check_repeat |=> word_reg.bits[15:4] == ~$past(word_reg.bits[15:4]))
    else $error("two-word pattern did not alternate");

  a_format_bypass: assert property (
    (s_plain_build and (i_cfg.pattern == PAT_CHECK && !same_pat
     && i_cfg.twos && i_cfg.wlen == LEN_12))
    |=> word_reg.bits == (CHECK_A & 16'hfff0))
    else $error("checkerboard converted by coding");

  a_user_word: assert property (
    (s_plain_build and (i_cfg.pattern == PAT_USER && !same_pat
     && i_cfg.wlen == LEN_14))
    |=> word_reg.bits[15:8] == $past(user_reg[0]))
    else $error("user word 1 not sent first");

  a_pn_fixed_len: assert property (
    (build && pn_sel) |=> word_reg.len == PN_WORD_BITS)
    else $error("pseudorandom word resized");

  a_pn_short_seed: assert property (
    !pn_sel |=> pn_short == PN9_FIRST)
    else $error("short sequence first sample wrong");

  a_pn_long_seed: assert property (
    !pn_sel |=> pn_long == PN23_FIRST)
    else $error("long sequence first sample wrong");

  a_twos_coding: assert property (
    (s_plain_build and (i_cfg.pattern == PAT_OFF && i_cfg.twos
     && i_cfg.wlen == LEN_12))
    |=> word_reg.bits[15:4] == {~$past(i_sample[11]), $past(i_sample[10:0])})
    else $error("twos complement coding wrong");

  a_word_hold: assert property (
    busy |=> $stable(word_reg) && $stable(cfg_reg))
    else $error("word changed before link took it");

endmodule : adc_serial_output_formatter

// ===== hdl/fmt_pkg.sv
// constants and carriers for the adc serial output formatter
package fmt_pkg;

  localparam logic [7:0] ADDR_USER_W1_A = 8'h19;
  localparam logic [7:0] ADDR_USER_W1_B = 8'h1a;
  localparam logic [7:0] ADDR_USER_W2_A = 8'h1b;
  localparam logic [7:0] ADDR_USER_W2_B = 8'h1c;
  localparam logic [7:0] USER_RESET = 8'h00;

  localparam int SAMPLE_W = 12;
  localparam logic [4:0] BITS_8 = 5'h08;
  localparam logic [4:0] BITS_10 = 5'h0a;
  localparam logic [4:0] BITS_12 = 5'h0c;
  localparam logic [4:0] BITS_14 = 5'h0e;
  localparam logic [4:0] PN_WORD_BITS = 5'h0c;

  localparam logic [3:0] PAT_OFF = 4'h0, PAT_MID = 4'h1, PAT_PFS = 4'h2,
    PAT_NFS = 4'h3, PAT_CHECK = 4'h4, PAT_PN_LONG = 4'h5, PAT_PN_SHORT = 4'h6,
    PAT_WORD_TGL = 4'h7, PAT_USER = 4'h8, PAT_BIT_TGL = 4'h9, PAT_SYNC = 4'ha,
    PAT_ONE_HIGH = 4'hb, PAT_MIXED = 4'hc;

  // patterns are held left aligned; the word length keeps the top bits
  localparam logic [15:0] MIDSCALE = 16'h8000;
  localparam logic [15:0] CHECK_A = 16'haaaa;
  localparam logic [15:0] CHECK_B = 16'h5555;
  localparam logic [15:0] MIX_8 = 16'ha300;
  localparam logic [15:0] MIX_10 = 16'h98c0;
  localparam logic [15:0] MIX_12 = 16'ha330;
  localparam logic [15:0] MIX_14 = 16'ha19c;

  localparam logic [8:0] PN9_SEED = 9'h0df;
  localparam logic [22:0] PN23_SEED = 23'h29b80a;
  localparam int PN9_TAP = 4;
  localparam int PN23_TAP = 17;
  localparam logic [11:0] PN9_FIRST = 12'hdf9;
  localparam logic [11:0] PN23_FIRST = 12'h591;

  // one link tick is 30 degrees of the bit clock
  localparam int TICKS_PER_BIT = 6;
  localparam int DEG_PER_BIT = 180;
  localparam int DEG_PER_TICK = DEG_PER_BIT / TICKS_PER_BIT;
  localparam int PHASE_DEFAULT_DEG = 90;
  localparam int PHASE_STEP_DEG = 60;
  localparam logic [4:0] PHASE_BASE_TICKS = 5'(PHASE_DEFAULT_DEG / DEG_PER_TICK);
  localparam logic [4:0] PHASE_STEP_TICKS = 5'(PHASE_STEP_DEG / DEG_PER_TICK);
  localparam logic [4:0] DCO_PERIOD_TICKS = 5'(2 * TICKS_PER_BIT);

  typedef enum logic [1:0] {LEN_12, LEN_8, LEN_10, LEN_14} wlen_e;

  typedef struct packed {
    logic [2:0] dco_phase;
    wlen_e wlen;
    logic lsb_first;
    logic invert;
    logic twos;
    logic [3:0] pattern;
  } fmt_cfg_s;

  typedef struct packed {
    logic [15:0] bits;
    logic [4:0] len;
  } lane_word_s;

  localparam lane_word_s IDLE_WORD = {16'h0000, BITS_12};

endpackage : fmt_pkg

// ===== hdl/pn_source.sv
// short and long pseudorandom word generators, twelve bits per advance
module pn_source
  import fmt_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_rstn,
  input wire logic i_restart,
  input wire logic i_advance,
  output logic [11:0] o_short_word,
  output logic [11:0] o_long_word
);
  logic [8:0] s9_reg;
  logic [8:0] s9_next;
  logic [22:0] s23_reg;
  logic [22:0] s23_next;

  always_comb
  begin
    s9_next = s9_reg;
    s23_next = s23_reg;
    // shift first, then emit the new top bit: the seed's top bit is skipped and the long stream is inverted
    for (int i = 11; i >= 0; i--)
    begin
      s9_next = {s9_next[7:0], s9_next[8] ^ s9_next[PN9_TAP]};
      o_short_word[i] = s9_next[8];
      s23_next = {s23_next[21:0], s23_next[22] ^ s23_next[PN23_TAP]};
      o_long_word[i] = ~s23_next[22];
    end
    if (i_restart)
    begin
      s9_next = PN9_SEED;
      s23_next = PN23_SEED;
    end
    else if (!i_advance)
    begin
      s9_next = s9_reg;
      s23_next = s23_reg;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      s9_reg <= PN9_SEED;
      s23_reg <= PN23_SEED;
    end
    else
    begin
      s9_reg <= s9_next;
      s23_reg <= s23_next;
    end
  end

endmodule : pn_source

// ===== hdl/lane_serializer.sv
// link-clock serializer driving lane data, bit clock and frame clock
module lane_serializer
  import fmt_pkg::*;
#(
  parameter int TICKS_PER_BIT_P = TICKS_PER_BIT
)
(
  input wire logic i_link_clk,
  input wire logic i_rstn,
  input wire lane_word_s i_word,
  input wire logic i_req_tgl,
  input wire logic [2:0] i_phase,
  output logic o_ack_tgl,
  output logic o_data,
  output logic o_dco,
  output logic o_fco
);
  logic req_s1, req_s2, ack_reg, ack_next, new_word, last_tick, last_bit;
  logic data_next, dco_next, fco_next;
  logic [2:0] ph_s2, ph_next, tick_reg, tick_next;
  logic [4:0] bit_reg, bit_next, pos, dly, rel;
  logic [15:0] sh_reg, sh_next;
  lane_word_s held_reg, held_next;

  always_comb
  begin
    last_tick = tick_reg == 3'(TICKS_PER_BIT_P - 1);
    last_bit = bit_reg == held_reg.len - 5'h01;
    new_word = req_s2 != ack_reg;
    tick_next = last_tick ? 3'h0 : tick_reg + 3'h1;
    bit_next = bit_reg;
    sh_next = sh_reg;
    held_next = held_reg;
    ack_next = ack_reg;
    ph_next = ph_s2;
    if (last_tick && last_bit)
    begin
      // a word is only swapped in here, so frames never tear
      bit_next = 5'h00;
      held_next = new_word ? i_word : held_reg;
      // phase rides with the word: stable while its request is unacked
      ph_next = new_word ? i_phase : ph_s2;
      sh_next = held_next.bits;
      ack_next = req_s2;
    end
    else if (last_tick)
    begin
      bit_next = bit_reg + 5'h01;
      sh_next = {sh_reg[14:0], 1'b0};
    end
    // two bits per bit-clock period: both edges carry data
    pos = {2'b00, tick_reg} + (bit_reg[0] ? 5'(TICKS_PER_BIT_P) : 5'h00);
    dly = PHASE_BASE_TICKS + 5'(PHASE_STEP_TICKS * ph_s2);
    if (dly >= DCO_PERIOD_TICKS)
      dly = dly - DCO_PERIOD_TICKS;
    rel = pos + DCO_PERIOD_TICKS - dly;
    if (rel >= DCO_PERIOD_TICKS)
      rel = rel - DCO_PERIOD_TICKS;
    dco_next = rel < 5'(TICKS_PER_BIT_P);
    data_next = sh_reg[15];
    fco_next = bit_reg < {1'b0, held_reg.len[4:1]};
  end

  always_ff @(posedge i_link_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      {req_s1, req_s2, ack_reg} <= 3'h0;
      {ph_s2, tick_reg} <= 6'h00;
      bit_reg <= 5'h00;
      sh_reg <= 16'h0000;
      held_reg <= IDLE_WORD;
      {o_data, o_dco, o_fco} <= 3'h0;
    end
    else
    begin
      req_s1 <= i_req_tgl;
      req_s2 <= req_s1;
      ph_s2 <= ph_next;
      tick_reg <= tick_next;
      bit_reg <= bit_next;
      sh_reg <= sh_next;
      held_reg <= held_next;
      ack_reg <= ack_next;
      o_data <= data_next;
      o_dco <= dco_next;
      o_fco <= fco_next;
    end
  end

  assign o_ack_tgl = ack_reg;

  default clocking cb @(posedge i_link_clk); endclocking
  default disable iff (!i_rstn);

  a_dco_default_phase: assert property (
    (ph_s2 == 3'h0 && pos == 5'h02) |=> !o_dco ##1 o_dco)
    else $error("bit clock not 90 degrees after data edge");

  a_fco_word_start: assert property (
    (last_tick && last_bit) |=> ##1 o_fco)
    else $error("frame clock low at word start");

endmodule : lane_serializer

// ===== dv/lane_receiver.sv
// behavioural receiver that captures the serial lane and splits it into words
module lane_receiver
(
  input wire logic i_rstn,
  input wire logic i_data,
  input wire logic i_bit_clk,
  input wire logic i_frame_clk,
  output logic [15:0] o_word,
  output logic [4:0] o_len,
  output logic [31:0] o_count
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [15:0] shift_reg;
  logic [4:0] cnt;
  logic frame_prev;

  // double data rate: each edge of the bit clock carries one bit
  always @(posedge i_bit_clk or negedge i_bit_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      shift_reg <= '0;
      cnt <= '0;
      frame_prev <= 1'b0;
      o_word <= '0;
      o_len <= '0;
      o_count <= '0;
    end
    else
    begin
      frame_prev <= i_frame_clk;
      // a rising frame clock closes the previous word; the first one closes nothing
      if (i_frame_clk && !frame_prev)
      begin
        if (cnt != 5'h00)
        begin
          o_word <= shift_reg;
          o_len <= cnt;
          o_count <= o_count + 32'h1;
        end
        shift_reg <= {15'h0000, i_data};
        cnt <= 5'h01;
      end
      else
      begin
        shift_reg <= {shift_reg[14:0], i_data};
        cnt <= cnt + 5'h01;
      end
    end
  end
endmodule : lane_receiver

// ===== dv/tb_adc_serial_output_formatter.sv
// self-checking bench for the adc serial output formatter
module tb_adc_serial_output_formatter
  import fmt_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  localparam logic [11:0] PN_SHORT_EXP [3] = '{12'hdf9, 12'h353, 12'h301};
  localparam logic [11:0] PN_LONG_EXP [3] = '{12'h591, 12'hfd7, 12'h0a3};

  logic i_core_clk = 1'b0;
  logic i_link_clk = 1'b0;
  logic i_rstn = 1'b0;
  logic [11:0] sample = '0;
  logic valid = 1'b0;
  fmt_cfg_s cfg = '0;
  logic wr_en = 1'b0;
  logic [7:0] reg_addr = '0;
  logic [7:0] reg_wdata = '0;
  logic [7:0] rdata;
  logic pend, sdata, dco, fco;
  logic [15:0] rx_word;
  logic [4:0] rx_len;
  logic [31:0] rx_count;
  logic [7:0] ureg [4];
  int n_fail = 0;
  int compares = 0;

  initial forever #50 i_core_clk = ~i_core_clk;
  // link clock offset so its edges never meet the core clock's sampling edges
  initial
  begin
    #37;
    forever #80 i_link_clk = ~i_link_clk;
  end

  adc_serial_output_formatter DUT
  (
    .i_core_clk(i_core_clk),
    .i_link_clk(i_link_clk),
    .i_rstn(i_rstn),
    .i_sample(sample),
    .i_sample_valid(valid),
    .i_cfg(cfg),
    .i_reg_wr(wr_en),
    .i_reg_addr(reg_addr),
    .i_reg_wdata(reg_wdata),
    .o_reg_rdata(rdata),
    .o_word_pending(pend),
    .o_serial_data(sdata),
    .o_bit_rate_output_clock(dco),
    .o_word_frame_output_clock(fco)
  );

  lane_receiver rx
  (
    .i_rstn(i_rstn),
    .i_data(sdata),
    .i_bit_clk(dco),
    .i_frame_clk(fco),
    .o_word(rx_word),
    .o_len(rx_len),
    .o_count(rx_count)
  );

  function automatic logic [4:0] len_of(input fmt_cfg_s c);
    if (c.pattern == PAT_PN_SHORT || c.pattern == PAT_PN_LONG)
      return PN_WORD_BITS;
    case (c.wlen)
      LEN_8: return BITS_8;
      LEN_10: return BITS_10;
      LEN_14: return BITS_14;
      default: return BITS_12;
    endcase
  endfunction : len_of

  // expected lane word, right aligned, first bit sent in the top position
  function automatic logic [15:0] build(input fmt_cfg_s c, input logic [11:0] s, input logic alt);
    logic [4:0] n;
    logic [15:0] v;
    logic [15:0] r;
    n = len_of(c);
    case (c.pattern)
      PAT_MID, PAT_ONE_HIGH: v = MIDSCALE;
      PAT_PFS: v = 16'hffff;
      PAT_NFS: v = 16'h0000;
      PAT_CHECK: v = alt ? CHECK_B : CHECK_A;
      PAT_WORD_TGL: v = alt ? 16'h0000 : 16'hffff;
      PAT_USER: v = alt ? {ureg[2], ureg[3]} : {ureg[0], ureg[1]};
      PAT_BIT_TGL: v = CHECK_A;
      PAT_SYNC: v = ((16'h0001 << (n / 2)) - 16'h0001) << (16 - n);
      PAT_MIXED: v = (n == BITS_8) ? MIX_8 : (n == BITS_10) ? MIX_10 :
        (n == BITS_12) ? MIX_12 : MIX_14;
      default: v = {s, 4'h0};
    endcase
    if (c.twos && c.pattern inside {PAT_OFF, PAT_MID, PAT_PFS, PAT_NFS, PAT_PN_LONG,
        PAT_PN_SHORT, [4'hd:4'hf]})
      v[15] = ~v[15];
    r = v >> (16 - n);
    if (c.lsb_first)
      for (int i = 0; i < 16; i++)
        r[i] = (i < n) ? v[15 - i] : 1'b0;
    if (c.invert)
      r = r ^ ((16'h0001 << n) - 16'h0001);
    return r;
  endfunction : build

  function automatic fmt_cfg_s rand_cfg();
    fmt_cfg_s c;
    c = '0;
    c.wlen = wlen_e'($urandom_range(3));
    c.lsb_first = 1'($urandom);
    c.invert = 1'($urandom);
    c.twos = 1'($urandom);
    return c;
  endfunction : rand_cfg

  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp)
    begin
      n_fail++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic report_and_stop();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : report_and_stop

  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    @(negedge i_core_clk);
    wr_en = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge i_core_clk);
    wr_en = 1'b0;
  endtask : reg_write

  task automatic reg_read(input logic [7:0] a, input logic [7:0] e);
    @(negedge i_core_clk);
    reg_addr = a;
    repeat (2) @(negedge i_core_clk);
    chk("reg_rdata", {8'h00, e}, {8'h00, rdata});
  endtask : reg_read

  task automatic wait_rx(input int n);
    logic [31:0] c0;
    int k;
    c0 = rx_count;
    k = 0;
    while (rx_count < c0 + 32'(n) && k < 3000)
    begin
      @(negedge i_core_clk);
      k++;
    end
    chk("rx_words", 16'(n), 16'(rx_count - c0));
  endtask : wait_rx

  // one word offered; with drop a second offer lands while the first waits
  task automatic send(input fmt_cfg_s c, input logic [11:0] s, input logic drop);
    int k;
    @(negedge i_core_clk);
    cfg = c;
    sample = s;
    valid = 1'b1;
    @(negedge i_core_clk);
    valid = 1'b0;
    k = 0;
    while (pend !== 1'b1 && k < 20)
    begin
      @(negedge i_core_clk);
      k++;
    end
    if (drop)
    begin
      sample = ~s;
      valid = 1'b1;
      @(negedge i_core_clk);
      valid = 1'b0;
    end
    k = 0;
    while (pend !== 1'b0 && k < 3000)
    begin
      @(negedge i_core_clk);
      k++;
    end
    chk("word_pending", 16'h0000, {15'h0000, pend});
    wait_rx(2);
  endtask : send

  // link ticks from a frame start to the next bit clock edge
  task automatic measure(output int n);
    logic f0;
    logic d0;
    int g;
    f0 = 1'b1;
    g = 0;
    while (g < 200)
    begin
      @(negedge i_link_clk);
      g++;
      if (fco === 1'b1 && f0 === 1'b0)
        break;
      f0 = fco;
    end
    d0 = dco;
    n = 0;
    while (n < 12 && dco === d0)
    begin
      @(negedge i_link_clk);
      n++;
    end
  endtask : measure

  initial
  begin
    #8000000;
    n_fail++;
    $display("BAD watchdog expected done seen timeout");
    report_and_stop();
  end

  initial
  begin
    fmt_cfg_s c;
    logic [11:0] s;
    int t;
    void'($urandom(32'h116fa3a0));
    repeat (6) @(negedge i_core_clk);
    chk("reset_outputs", 16'h0000, {4'h0, rdata, pend, sdata, dco, fco});
    i_rstn = 1'b1;
    foreach (ureg[i])
      reg_read(8'(ADDR_USER_W1_A + i), USER_RESET);
    foreach (ureg[i])
    begin
      ureg[i] = 8'($urandom);
      reg_write(8'(ADDR_USER_W1_A + i), ureg[i]);
    end
    reg_write(8'h18, 8'h5a);
    reg_write(8'h1d, 8'ha5);
    foreach (ureg[i])
      reg_read(8'(ADDR_USER_W1_A + i), ureg[i]);
    reg_read(8'h18, 8'h00);
    reg_read(8'h1d, 8'h00);
    $display("test registers done");
    for (int k = 0; k < 24; k++)
    begin
      c = rand_cfg();
      c.wlen = wlen_e'(2'(k));
      s = (k < 4) ? (k[0] ? 12'h001 : 12'h800) : 12'($urandom);
      send(c, s, k[0]);
      chk("sample_word", build(c, s, 1'b0), rx_word);
      chk("sample_len", {11'h000, len_of(c)}, {11'h000, rx_len});
    end
    $display("test samples done");
    for (int p = 1; p < 14; p++)
      if (p != 5 && p != 6)
      begin
        c = rand_cfg();
        c.pattern = 4'(p);
        for (int a = 0; a < 2; a++)
        begin
          s = 12'($urandom);
          send(c, s, 1'b0);
          chk("pattern_word", build(c, s, a[0]), rx_word);
          chk("pattern_len", {11'h000, len_of(c)}, {11'h000, rx_len});
        end
      end
    $display("test patterns done");
    c = rand_cfg();
    c.lsb_first = 1'b0;
    c.invert = 1'b0;
    c.twos = 1'b0;
    c.pattern = PAT_PN_SHORT;
    foreach (PN_SHORT_EXP[i])
    begin
      send(c, 12'h000, 1'b0);
      chk("pn_short", build(c, PN_SHORT_EXP[i], 1'b0), rx_word);
      chk("pn_short_len", 16'h000c, {11'h000, rx_len});
    end
    c.pattern = PAT_OFF;
    send(c, 12'h000, 1'b0);
    c.pattern = PAT_PN_LONG;
    foreach (PN_LONG_EXP[i])
    begin
      send(c, 12'h000, 1'b0);
      chk("pn_long", build(c, PN_LONG_EXP[i], 1'b0), rx_word);
      chk("pn_long_len", 16'h000c, {11'h000, rx_len});
    end
    $display("test pseudorandom done");
    for (int k = 0; k < 8; k++)
    begin
      c = '0;
      c.pattern = PAT_BIT_TGL;
      c.dco_phase = 3'(k);
      send(c, 12'h000, 1'b0);
      // the frame where the phase jumps may carry a stray bit clock edge
      wait_rx(1);
      chk("phase_word", build(c, 12'h000, 1'b0), rx_word);
      measure(t);
      chk("phase_ticks", 16'((3 + 2 * k) % 6), 16'(t));
    end
    $display("test clock phase done");
    report_and_stop();
  end
endmodule : tb_adc_serial_output_formatter
